// *** shared/sr_cfg.svh ***
// Timing constants and reset values for the self refresh sequencer.
`ifndef SR_CFG_SVH
`define SR_CFG_SVH

// ****************************************
// Clock rates
// ****************************************
// The controller clock period in ns; the memory clock period is twice it.
`define CLK_NS 25
`define CK_NS (2 * `CLK_NS)
// A least time in ns rounded up to whole memory clock periods.
`define NCK_UP(ns) (((ns) + `CK_NS - 1) / `CK_NS)

// ****************************************
// Times in ns
// ****************************************
`define T_RFC1_NS 350
`define T_RFC4_NS 160
`define T_XS_NS (`T_RFC1_NS + 10)
`define T_XS_FAST_NS (`T_RFC4_NS + 10)
`define T_XS_ABORT_NS (`T_RFC4_NS + 10)
`define T_MPX_S_NS 12
`define T_MPX_LH_NS 12

// ****************************************
// Counts in memory clock periods
// ****************************************
`define RFC1_NCK `NCK_UP(`T_RFC1_NS)
`define XS_NCK `NCK_UP(`T_XS_NS)
`define XS_FAST_NCK `NCK_UP(`T_XS_FAST_NS)
`define XS_ABORT_NCK `NCK_UP(`T_XS_ABORT_NS)
`define MPX_S_NCK `NCK_UP(`T_MPX_S_NS)
`define MPX_LH_NCK `NCK_UP(`T_MPX_LH_NS)
`define XSDLL_NCK 768
`define CKESR_NCK 4
`define CKESR_PAR_NCK 8
`define CKSRE_NCK 8
`define CKSRX_NCK 8
`define CAL_NCK 3

// ****************************************
// Reset values
// ****************************************
`define CNT_RST 11'h7ff

`endif

// *** shared/sr_pkg.sv ***
// Types shared by the self refresh sequencer modules.
package sr_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		ST_READY   = 3'h1,
		ST_HOLD    = 3'h2,
		ST_RESTART = 3'h4
	} sr_state_t;

	// Commands the user may ask for.
	typedef enum logic [3:0] {
		CMD_DES      = 4'h0,
		CMD_NOP      = 4'h1,
		CMD_ACT      = 4'h2,
		CMD_PRE      = 4'h3,
		CMD_REF      = 4'h4,
		CMD_ZQ       = 4'h5,
		CMD_MRS_FAST = 4'h6,
		CMD_MRS      = 4'h7,
		CMD_RD       = 4'h8,
		CMD_WR       = 4'h9
	} cmd_kind_t;

	// Levels driven onto the memory command pins.
	typedef struct packed {
		logic        cke;
		logic        cs_n;
		logic        act_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic        odt;
		logic [13:0] addr;
		logic [3:0]  bank;
	} ddr_pins_t;

	// Mode settings the user keeps in step with the memory.
	typedef struct packed {
		logic abort_en;
		logic cal_mode;
		logic parity_on;
		logic gear_down;
		logic nop_exit;
		logic stop_clock;
	} sr_cfg_t;

	// One command request.
	typedef struct packed {
		cmd_kind_t   kind;
		logic [13:0] addr;
		logic [3:0]  bank;
	} user_cmd_t;

	// Whole state of the sequencer.
	typedef struct packed {
		sr_state_t   st;
		logic        phase;
		logic        ck_run;
		logic        ck;
		ddr_pins_t   pins;
		logic [10:0] cnt;
		logic        ref_owed;
		logic        nop_mode;
		logic        cal;
		logic        par;
		logic        abort;
	} ctrl_state_t;

	// Whole state of a down timer.
	typedef struct packed {
		logic [10:0] cnt;
	} timer_state_t;

endpackage

// *** rtl/sr_down_timer.sv ***
// Down counter in memory clock periods, used for the refresh recovery wait.
`timescale 1ns/1ps
module sr_down_timer (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [10:0] value,
	output logic             done
);

	sr_pkg::timer_state_t s;
	sr_pkg::timer_state_t next_s;

	// A load wins over counting; the count stops at zero.
	always_comb begin
		next_s = s;
		if (load) begin
			next_s.cnt = value;
		end else if (tick && s.cnt != 11'h000) begin
			next_s.cnt = 11'(s.cnt - 11'h001);
		end
	end

	// Registers the state.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// The wait is over once the count is zero.
	assign done = (s.cnt == 11'h000);

endmodule

// *** rtl/sr_ctrl.sv ***
// Memory controller side sequencer for self refresh entry, residency and exit.
// Behaviour
// [R1] Entry is CS, RAS, CAS, CKE low.
// [R2] Enter only when the memory is idle.
// [R3] Hold CKE low throughout self refresh.
// [R4] Memory turns termination off inside self refresh.
// [R5] Memory turns its DLL off, resets on exit.
// [R6] Memory ignores inputs except CKE and reset.
// [R7] Writes wait tXSDLL when the reference sleeps.
// [R8] Memory refreshes once within tCKE of entry.
// [R9] Stay in at least tCKESR or tCKESR_PAR.
// [R10] Stop clock after tCKSRE; run tCKSRX before exit.
// [R11] Exit is CKE high with a deselect.
// [R12] Plain commands wait tXS after exit.
// [R13] ZQ and limited mode writes wait tXS_FAST.
// [R14] Reads and writes wait tXSDLL after exit.
// [R15] CKE stays high through tXSDLL; the code drops it on re-entry once tXS and the extra refresh are done.
// [R16] Only deselects during tXS; the code also passes NOPs, and ZQ and limited mode writes after tXS_FAST.
// [R17] ODT held off during tXSDLL.
// [R18] Re-entry needs tXS and one extra refresh.
// [R19] Latency mode adds three clocks to waits.
// [R20] tXS is tRFC1 plus 10 ns.
// [R21] Abort mode shortens the wait to tXS_ABORT.
// [R22] NOP exit only with parity, latency, gear-down off.
// [R23] Memory keeps its own refresh timer running.
`timescale 1ns/1ps
`include "sr_cfg.svh"
module sr_ctrl (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              sr_enter,
	input  wire logic              idle_ok,
	input  wire sr_pkg::sr_cfg_t   cfg,
	input  wire logic              cmd_valid,
	input  wire sr_pkg::user_cmd_t cmd,
	output logic                   cmd_ready,
	input  wire logic              odt_req,
	output sr_pkg::ddr_pins_t      dram,
	output logic                   dram_ck_t,
	output logic                   dram_ck_c,
	output logic                   in_self_refresh,
	output logic                   xs_met,
	output logic                   dll_met,
	output logic                   refresh_owed
);

	// ****************************************
	// Constants
	// ****************************************
	localparam logic [10:0] XS_C       = 11'(`XS_NCK);
	localparam logic [10:0] XS_FAST_C  = 11'(`XS_FAST_NCK);
	localparam logic [10:0] XS_ABORT_C = 11'(`XS_ABORT_NCK);
	localparam logic [10:0] XSDLL_C    = 11'(`XSDLL_NCK);
	localparam logic [10:0] CKESR_C    = 11'(`CKESR_NCK);
	localparam logic [10:0] CKESR_P_C  = 11'(`CKESR_PAR_NCK);
	localparam logic [10:0] CKSRE_C    = 11'(`CKSRE_NCK);
	localparam logic [10:0] CKSRX_C    = 11'(`CKSRX_NCK);
	localparam logic [10:0] CAL_C      = 11'(`CAL_NCK);
	localparam logic [10:0] MPX_S_C    = 11'(`MPX_S_NCK);
	localparam logic [10:0] MPX_LH_C   = 11'(`MPX_LH_NCK);
	localparam logic [10:0] RFC1_C     = 11'(`RFC1_NCK);

	// ****************************************
	// State and helpers
	// ****************************************
	sr_pkg::ctrl_state_t s;
	sr_pkg::ctrl_state_t next_s;
	logic                tick;
	logic                rfc_done;
	logic                ref_go;
	logic                enter_ok;
	logic                nop_win;
	logic                class_ok;
	logic [10:0]         cal_add;
	logic [10:0]         xs_t;
	logic [10:0]         fast_t;
	logic [10:0]         dll_t;
	logic [10:0]         ckesr_t;

	// Builds the pin levels of one command with CKE high.
	function automatic sr_pkg::ddr_pins_t encode(input sr_pkg::user_cmd_t c);
		sr_pkg::ddr_pins_t p;
		p = '{cke: 1'b1, cs_n: 1'b0, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
			we_n: 1'b1, odt: 1'b0, addr: c.addr, bank: c.bank};
		case (c.kind)
			sr_pkg::CMD_NOP: p.cs_n = 1'b0;
			sr_pkg::CMD_ACT: p.act_n = 1'b0;
			sr_pkg::CMD_PRE: {p.ras_n, p.we_n} = 2'h0;
			sr_pkg::CMD_REF: {p.ras_n, p.cas_n} = 2'h0;
			sr_pkg::CMD_ZQ: p.we_n = 1'b0;
			sr_pkg::CMD_MRS_FAST, sr_pkg::CMD_MRS: {p.ras_n, p.cas_n, p.we_n} = 3'h0;
			sr_pkg::CMD_RD: p.cas_n = 1'b0;
			sr_pkg::CMD_WR: {p.cas_n, p.we_n} = 2'h0;
			default: p.cs_n = 1'b1;
		endcase
		return p;
	endfunction

	// Deselect, or NOP when the exit shares the bus, with a given CKE.
	function automatic sr_pkg::ddr_pins_t idle_pins(input logic cke, input logic nop);
		sr_pkg::ddr_pins_t p;
		p = '{cke: cke, cs_n: ~nop, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
			we_n: 1'b1, odt: 1'b0, addr: 14'h0000, bank: 4'h0};
		return p;
	endfunction

	// ****************************************
	// Exit windows
	// ****************************************
	// Latency mode stretches every post-exit wait by three clocks.
	assign cal_add = s.cal ? CAL_C : 11'h000;                          // see [R19]
	// Abort mode shortens the plain-command wait.
	assign xs_t    = 11'((s.abort ? XS_ABORT_C : XS_C) + cal_add);   // see [R20] see [R21]
	assign fast_t  = 11'(XS_FAST_C + cal_add);                        // see [R13]
	assign dll_t   = 11'(XSDLL_C + cal_add);                          // see [R14]
	assign ckesr_t = s.par ? CKESR_P_C : CKESR_C;                     // see [R9]
	// Only NOPs may follow a shared-bus exit for the first tMPX_LH.
	assign nop_win = s.nop_mode && s.cnt < MPX_LH_C;                  // see [R22]

	// Commands are gated by the window their class needs.
	always_comb begin
		unique case (cmd.kind)
			sr_pkg::CMD_DES, sr_pkg::CMD_NOP: class_ok = 1'b1;
			sr_pkg::CMD_ZQ, sr_pkg::CMD_MRS_FAST: class_ok = s.cnt >= fast_t; // see [R13]
			sr_pkg::CMD_ACT, sr_pkg::CMD_PRE,
			sr_pkg::CMD_REF, sr_pkg::CMD_MRS: class_ok = s.cnt >= xs_t;     // see [R12] see [R16]
			// Writes always wait tXSDLL, which also covers a sleeping reference.
			sr_pkg::CMD_RD, sr_pkg::CMD_WR: class_ok = s.cnt >= dll_t;      // see [R14] see [R7]
			default: class_ok = 1'b0;
		endcase
	end

	// Re-entry needs an idle memory, tXS, and the extra refresh done.
	assign enter_ok = s.st == sr_pkg::ST_READY && sr_enter && idle_ok
		&& !s.ref_owed && rfc_done && s.cnt >= xs_t;               // see [R2] see [R18]

	// Pins change only at a falling memory clock edge.
	assign tick = s.phase;
	assign cmd_ready = tick && s.st == sr_pkg::ST_READY && !enter_ok && !nop_win && class_ok;
	assign ref_go = cmd_valid && cmd_ready && cmd.kind == sr_pkg::CMD_REF;

	// ****************************************
	// Refresh recovery timer
	// ****************************************
	sr_down_timer u_rfc (
		.clock  (clock),
		.resetn (resetn),
		.tick   (tick),
		.load   (ref_go),
		.value  (RFC1_C),
		.done   (rfc_done)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	// Next state, evaluated at each falling memory clock edge.
	always_comb begin
		next_s = s;
		next_s.phase = ~s.phase;
		if (tick) begin
			if (s.cnt != `CNT_RST) begin
				next_s.cnt = 11'(s.cnt + 11'h001);
			end
			unique case (s.st)
				sr_pkg::ST_READY: begin
					next_s.pins = idle_pins(1'b1, nop_win);    // see [R15] see [R16]
					if (enter_ok) begin
						next_s.pins = encode('{kind: sr_pkg::CMD_REF, addr: 14'h0000,
							bank: 4'h0});
						next_s.pins.cke = 1'b0;                 // see [R1]
						next_s.st = sr_pkg::ST_HOLD;
						next_s.cnt = 11'h000;
						next_s.cal = cfg.cal_mode;
						next_s.par = cfg.parity_on;
						next_s.abort = cfg.abort_en;
						next_s.nop_mode = cfg.nop_exit && !cfg.parity_on
							&& !cfg.cal_mode && !cfg.gear_down; // see [R22]
					end else begin
						if (cmd_valid && cmd_ready) begin
							next_s.pins = encode(cmd);
						end
						if (ref_go) begin
							next_s.ref_owed = 1'b0;             // see [R18]
						end
						next_s.pins.odt = odt_req && s.cnt >= dll_t; // see [R17]
					end
				end
				sr_pkg::ST_HOLD: begin
					// CKE low keeps the memory asleep; other pins are ignored.
					next_s.pins = idle_pins(1'b0, 1'b0);       // see [R3] see [R6]
					if (!sr_enter && s.cnt > ckesr_t) begin
						next_s.st = sr_pkg::ST_RESTART;         // see [R9]
						next_s.cnt = 11'h000;
						next_s.ck_run = 1'b1;
					end else begin
						next_s.ck_run = !(cfg.stop_clock && s.cnt > CKSRE_C); // see [R10]
					end
				end
				sr_pkg::ST_RESTART: begin
					next_s.pins = idle_pins(1'b0, 1'b0);       // see [R3]
					next_s.ck_run = 1'b1;
					if (s.cnt >= CKSRX_C && (!s.nop_mode || s.cnt >= MPX_S_C)) begin
						// Exit: CKE high with a deselect, or NOP on a shared bus.
						next_s.pins = idle_pins(1'b1, s.nop_mode); // see [R11] see [R22]
						next_s.st = sr_pkg::ST_READY;           // see [R10]
						next_s.cnt = 11'h001;
						next_s.ref_owed = 1'b1;                 // see [R18]
					end
				end
			endcase
		end
		next_s.ck = next_s.phase && next_s.ck_run;
	end

	// Registers the state; after reset the memory is awake and settled.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '{st: sr_pkg::ST_READY, phase: 1'b0, ck_run: 1'b1, ck: 1'b0,
				pins: '{cke: 1'b1, cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
				we_n: 1'b1, odt: 1'b0, addr: 14'h0000, bank: 4'h0},
				cnt: `CNT_RST, ref_owed: 1'b0, nop_mode: 1'b0, cal: 1'b0,
				par: 1'b0, abort: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Pins and clock come straight from the state register.
	assign dram = s.pins;
	assign dram_ck_t = s.ck;
	assign dram_ck_c = ~s.ck;
	assign in_self_refresh = s.st != sr_pkg::ST_READY;
	assign xs_met = s.st == sr_pkg::ST_READY && s.cnt >= xs_t;
	assign dll_met = s.st == sr_pkg::ST_READY && s.cnt >= dll_t;
	assign refresh_owed = s.ref_owed;

	// ****************************************
	// Assertions
	// ****************************************
	a_entry_encoding: assert property (@(posedge clock) disable iff (!resetn) // see [R1]
		$fell(s.pins.cke) |-> !s.pins.cs_n && !s.pins.ras_n && !s.pins.cas_n
			&& s.pins.we_n && s.pins.act_n)
		else $error("entry pins wrong");

	a_entry_idle: assert property (@(posedge clock) disable iff (!resetn) // see [R2]
		$fell(s.pins.cke) |-> $past(idle_ok) && $past(sr_enter))
		else $error("entry while not idle");

	a_cke_low_hold: assert property (@(posedge clock) disable iff (!resetn) // see [R3]
		s.st != sr_pkg::ST_READY |-> !s.pins.cke)
		else $error("CKE high in self refresh");

	a_residency_min: assert property (@(posedge clock) disable iff (!resetn) // see [R9]
		$fell(s.pins.cke) |-> !s.pins.cke [*8])
		else $error("self refresh too short");

	a_clock_stop_late: assert property (@(posedge clock) disable iff (!resetn) // see [R10]
		!s.ck_run |-> s.st == sr_pkg::ST_HOLD && s.cnt > CKSRE_C)
		else $error("clock stopped too early");

	a_clock_restart: assert property (@(posedge clock) disable iff (!resetn) // see [R10]
		$rose(s.pins.cke) |-> s.ck_run && $past(s.ck_run, 16))
		else $error("clock not stable before exit");

	a_des_after_exit: assert property (@(posedge clock) disable iff (!resetn) // see [R16]
		$rose(s.pins.cke) && !s.nop_mode |-> s.pins.cs_n [*8])
		else $error("command during tXS");

	a_nop_exit_ok: assert property (@(posedge clock) disable iff (!resetn) // see [R22]
		$rose(s.pins.cke) && !s.pins.cs_n |-> !s.cal && !s.par && s.pins.ras_n
			&& s.pins.cas_n && s.pins.we_n)
		else $error("illegal NOP exit");

	a_odt_off_dll: assert property (@(posedge clock) disable iff (!resetn) // see [R17]
		s.pins.odt |-> s.cnt > dll_t)
		else $error("ODT on during tXSDLL");

	a_rdwr_gate: assert property (@(posedge clock) disable iff (!resetn) // see [R14]
		$changed(s.pins) && s.pins.cke && !s.pins.cs_n && s.pins.ras_n
			&& !s.pins.cas_n |-> s.cnt > dll_t)
		else $error("read or write before tXSDLL");

	a_cke_high_dll: assert property (@(posedge clock) disable iff (!resetn) // see [R15]
		s.st == sr_pkg::ST_READY && s.cnt <= dll_t |-> s.pins.cke || s.cnt == `CNT_RST)
		else $error("CKE dropped during tXSDLL");

	a_reentry_ref: assert property (@(posedge clock) disable iff (!resetn) // see [R18]
		$fell(s.pins.cke) |-> !$past(s.ref_owed) && $past(rfc_done))
		else $error("re-entry without extra refresh");

	c_entry: cover property (@(posedge clock) disable iff (!resetn) $fell(s.pins.cke));
	c_clock_stop: cover property (@(posedge clock) disable iff (!resetn) $fell(s.ck_run));
	c_exit: cover property (@(posedge clock) disable iff (!resetn) $rose(s.pins.cke));
	c_nop_exit: cover property (@(posedge clock) disable iff (!resetn)
		$rose(s.pins.cke) && !s.pins.cs_n);

endmodule

// *** sim/ddr_dev_model.sv ***
// Behavioural memory device that registers the sequencer's pins on each rising memory clock edge.
`timescale 1ns/1ps
`include "sr_cfg.svh"
module ddr_dev_model #(
	parameter int REFI_NS = 500
) (
	input  wire logic              ck_t,
	input  wire sr_pkg::ddr_pins_t pins,
	input  wire sr_pkg::sr_cfg_t   cfg,
	output logic                   in_sr,
	output logic                   term_on,
	output logic                   dll_on,
	output int                     viol,
	output int                     exit_nops,
	output int                     int_refs
);
	int              since;
	int              xs_n;
	int              dll_n;
	logic            need_ref;
	realtime         t_in;
	sr_pkg::sr_cfg_t cfg_in;
	logic [4:0]      bus;

	// Command bits in the order select, activate, row, column, write.
	assign bus = {pins.cs_n, pins.act_n, pins.ras_n, pins.cas_n, pins.we_n};

	// The own refresh timer keeps running even with the clock stopped.
	initial begin
		int_refs = 0;
		forever begin
			#(REFI_NS);
			if (in_sr) int_refs++;
		end
	end

	// Decodes entry and exit and counts every break of the timing windows after exit.
	initial begin
		in_sr = 1'b0;
		term_on = 1'b1;
		dll_on = 1'b1;
		viol = 0;
		exit_nops = 0;
		since = 99999;
		need_ref = 1'b0;
		forever begin
			@(posedge ck_t);
			if (in_sr) begin
				// Only the clock enable is heeded while refreshing alone.
				if (pins.cke) begin
					in_sr = 1'b0;
					term_on = 1'b1;
					dll_on = 1'b1;
					since = 0;
					need_ref = 1'b1;
					if ($realtime - t_in < (cfg_in.parity_on ? `CKESR_PAR_NCK : `CKESR_NCK) * `CK_NS)
						viol++;
					if (bus == 5'h0f && cfg_in.nop_exit && !cfg_in.cal_mode && !cfg_in.parity_on)
						exit_nops++;
					else if (!pins.cs_n)
						viol++;
				end
			end else begin
				since++;
				if (!pins.cke && bus == 5'h09) begin
					if (need_ref || since < xs_n) viol++;
					in_sr = 1'b1;
					term_on = 1'b0;
					dll_on = 1'b0;
					t_in = $realtime;
					cfg_in = cfg;
					xs_n = (cfg.abort_en ? `XS_ABORT_NCK : `XS_NCK) + (cfg.cal_mode ? `CAL_NCK : 0);
					dll_n = `XSDLL_NCK + (cfg.cal_mode ? `CAL_NCK : 0);
				end else begin
					if (!pins.cke && since < dll_n) viol++;
					if (!pins.cs_n && bus != 5'h0f && since < xs_n) viol++;
					if ((bus == 5'h0d || bus == 5'h0c) && since < dll_n) viol++;
					if (pins.odt && since < dll_n) viol++;
					if (bus == 5'h09 && pins.cke) need_ref = 1'b0;
				end
			end
		end
	end
endmodule

// *** sim/test_sr_ctrl.sv ***
// Self-checking bench for the self refresh sequencer with a memory model on its pins.
`timescale 1ns/1ps
`include "sr_cfg.svh"
module test_sr_ctrl;
	logic              clock;
	logic              resetn;
	logic              sr_enter;
	logic              idle_ok;
	sr_pkg::sr_cfg_t   cfg;
	logic              cmd_valid;
	sr_pkg::user_cmd_t cmd;
	logic              cmd_ready;
	logic              odt_req;
	sr_pkg::ddr_pins_t dram;
	logic              ck_t;
	logic              ck_c;
	logic              in_self_refresh;
	logic              xs_met;
	logic              dll_met;
	logic              refresh_owed;
	logic              m_in_sr;
	logic              m_term;
	logic              m_dll;
	int                m_viol;
	int                m_nops;
	int                m_refs;
	int                n_mismatch = 0;
	int                comparisons = 0;
	int                gap;
	int                rises;
	int                xsn;
	int                exp_nops = 0;
	logic [3:0]        mode;
	logic [3:0]        modes [5] = '{4'h0, 4'h8, 4'h4, 4'h1, 4'h3};

	sr_ctrl dut (.clock(clock), .resetn(resetn), .sr_enter(sr_enter), .idle_ok(idle_ok),
		.cfg(cfg), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .odt_req(odt_req),
		.dram(dram), .dram_ck_t(ck_t), .dram_ck_c(ck_c), .in_self_refresh(in_self_refresh),
		.xs_met(xs_met), .dll_met(dll_met), .refresh_owed(refresh_owed));

	ddr_dev_model mem (.ck_t(ck_t), .pins(dram), .cfg(cfg), .in_sr(m_in_sr), .term_on(m_term),
		.dll_on(m_dll), .viol(m_viol), .exit_nops(m_nops), .int_refs(m_refs));

	// ****************************************
	// Clock, edge counting and checking tasks
	// ****************************************
	// Controller clock at 40 MHz.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Counts rising edges of the memory clock.
	always @(posedge ck_t) rises++;

	task automatic final_report();
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_range(input string what, input int lo, input int hi, input int got);
		comparisons++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic give_up(input string what);
		n_mismatch++;
		$display("BAD %s expected done seen waiting", what);
		final_report();
	endtask

	function automatic logic cond(input int sel);
		case (sel)
			0: return in_self_refresh;
			1: return dram.cke;
			2: return xs_met;
			default: return !refresh_owed;
		endcase
	endfunction

	// Waits at falling edges for the selected status, counting the cycles.
	task automatic wait_until(input int sel, input int lim, output int n);
		n = 0;
		while (cond(sel) !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > lim) give_up("status wait");
		end
	endtask

	// Holds a request until ready is seen mid-cycle, then checks the pins one cycle later.
	task automatic send(input sr_pkg::cmd_kind_t kind, input int lim, output int n);
		cmd.kind = kind;
		cmd_valid = 1'b1;
		n = 0;
		#2;
		while (cmd_ready !== 1'b1) begin
			@(negedge clock);
			#2;
			n++;
			if (n > lim) give_up("command wait");
		end
		@(negedge clock);
		cmd_valid = 1'b0;
		check_bit("command select", 1'b0, dram.cs_n);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	// Enters and leaves self refresh under each mode mix, then checks the exit windows.
	initial begin
		resetn = 1'b0;
		sr_enter = 1'b0;
		idle_ok = 1'b0;
		cfg = '0;
		cmd_valid = 1'b0;
		cmd = '0;
		odt_req = 1'b1;
		rises = 0;
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		sr_enter = 1'b1;
		repeat (20) @(negedge clock);
		check_bit("entry while busy", 1'b0, in_self_refresh);
		check_bit("clock pair", ~ck_t, ck_c);
		idle_ok = 1'b1;
		sr_enter = 1'b0;
		for (int i = 0; i < 5; i++) begin
			mode = modes[i];
			cfg = {mode[3], mode[2], mode[1], 1'b0, mode[0], i % 2 == 0};
			xsn = (mode[3] ? `XS_ABORT_NCK : `XS_NCK) + (mode[2] ? `CAL_NCK : 0);
			exp_nops += (mode == 4'h1) ? 1 : 0;
			sr_enter = 1'b1;
			wait_until(0, 60, gap);
			repeat (3) @(negedge clock);
			check_bit("memory asleep", 1'b1, m_in_sr);
			check_bit("termination", 1'b0, m_term);
			check_bit("memory dll", 1'b0, m_dll);
			rises = 0;
			repeat (60) @(negedge clock);
			check_bit("clock enable held", 1'b0, dram.cke);
			if (cfg.stop_clock) begin
				check_range("edges before stop", `CKSRE_NCK, 12, rises);
				gap = rises;
				repeat (10) @(negedge clock);
				check_range("stopped clock", gap, gap, rises);
			end
			sr_enter = 1'b0;
			rises = 0;
			wait_until(1, 400, gap);
			check_range("edges before exit", `CKSRX_NCK, 400, rises);
			wait_until(2, 400, gap);
			check_range("exit to first command", 2 * xsn - 2, 2 * xsn + 3, gap);
			check_bit("memory awake", 1'b0, m_in_sr);
			check_bit("termination back", 1'b1, m_term);
			check_range("nop exits", exp_nops, exp_nops, m_nops);
			check_bit("refresh owed", 1'b1, refresh_owed);
			if (i == 0) begin
				send(sr_pkg::CMD_RD, 2000, gap);
				check_range("wait for read", 2 * (`XSDLL_NCK - `XS_NCK) - 4,
					2 * (`XSDLL_NCK - `XS_NCK) + 4, gap);
				check_bit("dll window over", 1'b1, dll_met);
				repeat (4) @(negedge clock);
				check_bit("termination request", 1'b1, dram.odt);
			end
			sr_enter = 1'b1;
			repeat (20) @(negedge clock);
			check_bit("entry while refresh owed", 1'b0, in_self_refresh);
			sr_enter = 1'b0;
			send(sr_pkg::CMD_REF, 40, gap);
			wait_until(3, 20, gap);
			repeat (20) @(negedge clock);
		end
		check_range("window breaks", 0, 0, m_viol);
		check_bit("own refreshes", 1'b1, m_refs > 0);
		final_report();
	end
endmodule
